// File: core/dwg_core.sv
// Serial-programmed direct digital synthesis core: word decoder, registers,
// phase accumulator and output source selection.
// Assumes serial clock, frame sync and data arrive asynchronously from a host.
`timescale 1ns/10ps
// Operation
// - Two 28-bit frequency words, select bit picks.
// - Two 12-bit phase words, select bit picks.
// - Output frequency is clock times word over 2^28.
// - Phase shift is 2pi/4096 times phase word.
// - Address 01 writes word A, 10 word B.
// - Full mode: two writes, LSBs first then MSBs.
// - Half mode: half bit picks updated 14 bits.
// - Address 00 writes the control register.
// - Address 11 writes phase word, bit 13 picks.
// - Soft reset clears accumulator, keeps registers.
// - Converter code returns eight cycles after reset clears; bit output not blanked.
// - Sleep bits gate converter and core clock.
// - Clock off freezes output, and accumulator unless soft reset is set.
// - Writes still accepted while clock off.
// - Bit enable, mode, divide choose output source.
// - Triangle mode sends truncated phase, 10 bits.
// - Data sampled on serial clock falling edge.
module dwg_core (
  input  wire logic               core_clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               frame_sync_i,
  input  wire logic               serial_clk_i,
  input  wire logic               serial_data_in_i,
  output dwg_pkg::dwg_wave_t      wave_out_o
);

  // Synchroniser order is {frame_sync, serial clock, serial data}.
  logic [2:0]                        sync1_d, sync2_d, sync3_d;
  logic [2:0]                        sync1_q, sync2_q, sync3_q;
  logic [2:0]                        stab_d, stab_q;
  logic                              sclk_fall, frame_on, word_done;
  logic [dwg_pkg::WORD_W-1:0]        shift_d, shift_q, word;
  logic [dwg_pkg::BITCNT_W-1:0]      bits_d, bits_q;
  dwg_pkg::dwg_ctrl_t                ctrl_d, ctrl_q;
  logic [dwg_pkg::FREQ_W-1:0]        freq_a_d, freq_a_q, freq_b_d, freq_b_q, freq_sel;
  logic [dwg_pkg::PHASE_W-1:0]       ph_a_d, ph_a_q, ph_b_d, ph_b_q, ph_sel;
  logic [dwg_pkg::HALF_W-1:0]        lsb_hold_d, lsb_hold_q;
  logic                              pend_d, pend_q;
  logic [1:0]                        pend_addr_d, pend_addr_q;
  logic [dwg_pkg::FREQ_W-1:0]        acc_d, acc_q;
  logic [dwg_pkg::PHASE_W-1:0]       phase_d, phase_q, phase_dl_d, phase_dl_q;
  logic [dwg_pkg::DAC_W-1:0]         sine_code, tri_code, code_d, code_q;
  logic [dwg_pkg::BITCNT_W-1:0]      blank_d, blank_q;
  logic                              msb_prev_d, msb_prev_q, half_d, half_q, bit_d, bit_q;
  logic                              run;

  // Loads one 14-bit half of a frequency word.
  function automatic logic [dwg_pkg::FREQ_W-1:0] merge_half(
    input logic [dwg_pkg::FREQ_W-1:0] old,
    input logic [dwg_pkg::HALF_W-1:0] data,
    input logic                       upper
  );
    merge_half = upper ? {data, old[dwg_pkg::HALF_W-1:0]}
                       : {old[dwg_pkg::FREQ_W-1:dwg_pkg::HALF_W], data};
  endfunction

  // Three-stage synchronisers; a level counts once stages two and three agree.
  // Reset loads the idle levels so a short reset leaves no unknown stage behind.
  always_comb begin
    sync1_d = {frame_sync_i, serial_clk_i, serial_data_in_i};
    sync2_d = sync1_q;
    sync3_d = sync2_q;
    for (int i = 0; i < 3; i++) begin
      stab_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : stab_q[i];
    end
    if (sys_rst_i) begin
      sync1_d = 3'h6;
      sync2_d = 3'h6;
      sync3_d = 3'h6;
      stab_d  = 3'h6;
    end
  end

  always_ff @(posedge core_clk_i) begin
    sync1_q <= sync1_d;
    sync2_q <= sync2_d;
    sync3_q <= sync3_d;
    stab_q  <= stab_d;
  end

  // Falling serial clock inside a frame shifts one bit in, MSB first.
  assign sclk_fall = stab_q[1] && !stab_d[1];
  assign frame_on  = !stab_d[2];
  assign word      = {shift_q[dwg_pkg::WORD_W-2:0], sync3_q[0]};
  assign word_done = frame_on && sclk_fall && (bits_q == 4'hF);

  always_comb begin
    shift_d = shift_q;
    bits_d  = bits_q;
    if (sys_rst_i || !frame_on) begin
      bits_d = '0;
    end else if (sclk_fall) begin
      shift_d = word;
      bits_d  = bits_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    shift_q <= shift_d;
    bits_q  <= bits_d;
  end

  // Word decoder; it runs whatever the sleep bits say.
  always_comb begin
    ctrl_d      = ctrl_q;
    freq_a_d    = freq_a_q;
    freq_b_d    = freq_b_q;
    ph_a_d      = ph_a_q;
    ph_b_d      = ph_b_q;
    lsb_hold_d  = lsb_hold_q;
    pend_d      = pend_q;
    pend_addr_d = pend_addr_q;
    if (sys_rst_i) begin
      ctrl_d   = dwg_pkg::CTRL_RESET;
      freq_a_d = '0;
      freq_b_d = '0;
      ph_a_d   = '0;
      ph_b_d   = '0;
      pend_d   = 1'b0;
    end else if (word_done) begin
      case (word[15:14])
        dwg_pkg::ADDR_CTRL: begin
          ctrl_d.full_word_write   = word[dwg_pkg::BIT_FULL];
          ctrl_d.half_choice       = word[dwg_pkg::BIT_HALF];
          ctrl_d.freq_word_choice  = word[dwg_pkg::BIT_FSEL];
          ctrl_d.phase_word_choice = word[dwg_pkg::BIT_PSEL];
          ctrl_d.soft_reset        = word[dwg_pkg::BIT_RESET];
          ctrl_d.core_clock_off    = word[dwg_pkg::BIT_CLKOFF];
          ctrl_d.converter_off     = word[dwg_pkg::BIT_DACOFF];
          ctrl_d.bit_output_enable = word[dwg_pkg::BIT_OPBIT];
          ctrl_d.msb_direct        = word[dwg_pkg::BIT_DIRECT];
          ctrl_d.tri_mode          = word[dwg_pkg::BIT_MODE];
          pend_d                   = 1'b0;
        end
        dwg_pkg::ADDR_FREQ_A, dwg_pkg::ADDR_FREQ_B: begin
          if (!ctrl_q.full_word_write) begin
            if (word[14]) begin
              freq_a_d = merge_half(freq_a_q, word[13:0], ctrl_q.half_choice);
            end else begin
              freq_b_d = merge_half(freq_b_q, word[13:0], ctrl_q.half_choice);
            end
          end else if (pend_q && pend_addr_q == word[15:14]) begin
            pend_d = 1'b0;
            if (word[14]) begin
              freq_a_d = {word[13:0], lsb_hold_q};
            end else begin
              freq_b_d = {word[13:0], lsb_hold_q};
            end
          end else begin
            lsb_hold_d  = word[13:0];
            pend_d      = 1'b1;
            pend_addr_d = word[15:14];
          end
        end
        dwg_pkg::ADDR_PHASE: begin
          if (word[dwg_pkg::BIT_PHSEL]) begin
            ph_b_d = word[11:0];
          end else begin
            ph_a_d = word[11:0];
          end
        end
        default: begin
          pend_d = pend_q;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    ctrl_q      <= ctrl_d;
    freq_a_q    <= freq_a_d;
    freq_b_q    <= freq_b_d;
    ph_a_q      <= ph_a_d;
    ph_b_q      <= ph_b_d;
    lsb_hold_q  <= lsb_hold_d;
    pend_q      <= pend_d;
    pend_addr_q <= pend_addr_d;
  end

  // Register selection and accumulator; sleep freezes, soft reset clears.
  assign freq_sel = ctrl_q.freq_word_choice ? freq_b_q : freq_a_q;
  assign ph_sel   = ctrl_q.phase_word_choice ? ph_b_q : ph_a_q;
  assign run      = !ctrl_q.core_clock_off;

  always_comb begin
    acc_d      = acc_q;
    phase_d    = phase_q;
    phase_dl_d = phase_dl_q;
    blank_d    = blank_q;
    if (sys_rst_i || ctrl_q.soft_reset) begin
      acc_d      = '0;
      phase_d    = '0;
      phase_dl_d = '0;
      blank_d    = dwg_pkg::RESTART_LOAD;
    end else if (run) begin
      acc_d      = acc_q + freq_sel;
      phase_d    = acc_q[27:16] + ph_sel;
      phase_dl_d = phase_q;
      blank_d    = (blank_q != '0) ? blank_q - 4'h1 : blank_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    acc_q      <= acc_d;
    phase_q    <= phase_d;
    phase_dl_q <= phase_dl_d;
    blank_q    <= blank_d;
  end

  dwg_sine_conv u_sine (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .hold_i     (!run),
    .phase_i    (phase_q),
    .code_o     (sine_code)
  );

  // Triangle folds the top 11 phase bits into a 10-bit ramp.
  assign tri_code = phase_dl_q[11] ? ~phase_dl_q[10:1] : phase_dl_q[10:1];

  // Output source selection and the divide-by-two square wave.
  always_comb begin
    code_d     = code_q;
    bit_d      = bit_q;
    msb_prev_d = msb_prev_q;
    half_d     = half_q;
    if (sys_rst_i) begin
      code_d     = dwg_pkg::MIDSCALE;
      bit_d      = 1'b0;
      msb_prev_d = 1'b0;
      half_d     = 1'b0;
    end else if (run) begin
      msb_prev_d = sine_code[9];
      if (sine_code[9] && !msb_prev_q) begin
        half_d = !half_q;
      end
      if (ctrl_q.soft_reset || blank_q != '0) begin
        code_d = dwg_pkg::MIDSCALE;
      end else if (ctrl_q.bit_output_enable) begin
        code_d = dwg_pkg::MIDSCALE;
      end else if (ctrl_q.tri_mode) begin
        code_d = tri_code;
      end else begin
        code_d = sine_code;
      end
      bit_d = (ctrl_q.bit_output_enable && !ctrl_q.tri_mode)
              ? (ctrl_q.msb_direct ? sine_code[9] : half_q) : 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    code_q     <= code_d;
    bit_q      <= bit_d;
    msb_prev_q <= msb_prev_d;
    half_q     <= half_d;
  end

  assign wave_out_o.code     = code_q;
  assign wave_out_o.bit_val  = bit_q;
  assign wave_out_o.bit_sel  = ctrl_q.bit_output_enable;
  assign wave_out_o.conv_off = ctrl_q.converter_off;

  // Checks on the datapath and decoder.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_blank8;
    (code_q == dwg_pkg::MIDSCALE) [*8];
  endsequence

  a_acc_step: assert property (
    ($past(run) && !$past(ctrl_q.soft_reset) && !$past(sys_rst_i))
      |-> acc_q == $past(acc_q) + $past(freq_sel))
    else $error("Accumulator did not add the selected frequency word.");

  a_phase_add: assert property (
    (run && !ctrl_q.soft_reset)
      |=> phase_q == $past(acc_q[27:16]) + $past(ph_sel))
    else $error("Phase offset not added to accumulator top bits.");

  a_half_write: assert property (
    (word_done && word[15:14] == dwg_pkg::ADDR_FREQ_B && !ctrl_q.full_word_write
      && ctrl_q.half_choice)
      |=> freq_b_q[27:14] == $past(word[13:0]) && $stable(freq_b_q[13:0]))
    else $error("Half write to frequency word B went wrong.");

  a_full_pair: assert property (
    (word_done && word[15:14] == dwg_pkg::ADDR_FREQ_A && ctrl_q.full_word_write
      && pend_q && pend_addr_q == dwg_pkg::ADDR_FREQ_A)
      |=> freq_a_q == {$past(word[13:0]), $past(lsb_hold_q)})
    else $error("Second full write did not load all 28 bits.");

  a_ctrl_write: assert property (
    (word_done && word[15:14] == dwg_pkg::ADDR_CTRL)
      |=> ctrl_q.soft_reset == $past(word[dwg_pkg::BIT_RESET])
          && ctrl_q.tri_mode == $past(word[dwg_pkg::BIT_MODE]))
    else $error("Control word not taken.");

  a_phase_write: assert property (
    (word_done && word[15:13] == 3'h7) |=> ph_b_q == $past(word[11:0]) && $stable(ph_a_q))
    else $error("Phase word B write went wrong.");

  a_reset_clear: assert property (
    ctrl_q.soft_reset |=> acc_q == '0 && (!$past(run) || code_q == dwg_pkg::MIDSCALE)
                          && ($past(word_done) || $stable(freq_a_q)))
    else $error("Soft reset did not clear the accumulator.");

  a_restart_gap: assert property (
    $fell(ctrl_q.soft_reset) |-> s_blank8)
    else $error("Output left midscale before eight cycles.");

  a_sleep_hold: assert property (
    (ctrl_q.core_clock_off && $past(ctrl_q.core_clock_off) && !$past(ctrl_q.soft_reset))
      |-> $stable(code_q) && $stable(acc_q))
    else $error("Output moved while the core clock was off.");

  a_tri_path: assert property (
    (run && ctrl_q.tri_mode && !ctrl_q.bit_output_enable && !ctrl_q.soft_reset
      && blank_q == '0) |=> code_q == $past(tri_code))
    else $error("Triangle code not passed to the converter.");

endmodule

// File: core/dwg_pkg.sv
// Constants, field positions and carrier types of the waveform generator core.
// Assumes a single 20 MHz core clock and a three-wire serial write link.
package dwg_pkg;

  // Datapath widths.
  localparam int FREQ_W   = 28;
  localparam int PHASE_W  = 12;
  localparam int WORD_W   = 16;
  localparam int HALF_W   = 14;
  localparam int DAC_W    = 10;
  localparam int BITCNT_W = 4;
  localparam int SYNC_N   = 3;

  // Address field of a serial word, bits 15 and 14.
  localparam logic [1:0] ADDR_CTRL   = 2'h0;
  localparam logic [1:0] ADDR_FREQ_A = 2'h1;
  localparam logic [1:0] ADDR_FREQ_B = 2'h2;
  localparam logic [1:0] ADDR_PHASE  = 2'h3;

  // Bit positions inside the serial word.
  localparam int BIT_FULL   = 13;
  localparam int BIT_HALF   = 12;
  localparam int BIT_FSEL   = 11;
  localparam int BIT_PSEL   = 10;
  localparam int BIT_RESET  = 8;
  localparam int BIT_CLKOFF = 7;
  localparam int BIT_DACOFF = 6;
  localparam int BIT_OPBIT  = 5;
  localparam int BIT_DIRECT = 3;
  localparam int BIT_MODE   = 1;
  localparam int BIT_PHSEL  = 13;

  // Converter midscale code and restart latency after the soft reset clears.
  localparam logic [DAC_W-1:0]    MIDSCALE       = 10'h200;
  localparam int                  RESTART_CYCLES = 8;
  localparam logic [BITCNT_W-1:0] RESTART_LOAD   = BITCNT_W'(RESTART_CYCLES - 1);

  // Control register contents.
  typedef struct packed {
    logic full_word_write;
    logic half_choice;
    logic freq_word_choice;
    logic phase_word_choice;
    logic soft_reset;
    logic core_clock_off;
    logic converter_off;
    logic bit_output_enable;
    logic msb_direct;
    logic tri_mode;
  } dwg_ctrl_t;

  localparam dwg_ctrl_t CTRL_RESET = '0;

  // What leaves the core towards the output pin.
  typedef struct packed {
    logic [DAC_W-1:0] code;
    logic             bit_val;
    logic             bit_sel;
    logic             conv_off;
  } dwg_wave_t;

endpackage

// File: core/dwg_sine_conv.sv
// Phase-to-amplitude converter with a registered 10-bit output.
// Assumes the phase input is stable for one cycle; hold_i freezes the output.
`timescale 1ns/10ps
module dwg_sine_conv (
  input  wire logic                            core_clk_i,
  input  wire logic                            sys_rst_i,
  input  wire logic                            hold_i,
  input  wire logic [dwg_pkg::PHASE_W-1:0]     phase_i,
  output logic      [dwg_pkg::DAC_W-1:0]       code_o
);

  logic [9:0]             quarter;
  logic [21:0]            prod;
  logic [8:0]             mag;
  logic [dwg_pkg::DAC_W-1:0] code_d;
  logic [dwg_pkg::DAC_W-1:0] code_q;

  // Quarter-wave parabola: mirror in the second and fourth quadrants, negate in the second half.
  always_comb begin
    quarter = phase_i[10] ? ~phase_i[9:0] : phase_i[9:0];
    prod    = 22'(quarter) * (22'h000800 - 22'(quarter));
    mag     = prod[19:11];
    if (sys_rst_i) begin
      code_d = dwg_pkg::MIDSCALE;
    end else if (hold_i) begin
      code_d = code_q;
    end else if (phase_i[11]) begin
      code_d = 10'h1FF - {1'b0, mag};
    end else begin
      code_d = dwg_pkg::MIDSCALE + {1'b0, mag};
    end
  end

  // Output register.
  always_ff @(posedge core_clk_i) begin
    code_q <= code_d;
  end

  assign code_o = code_q;

endmodule

// File: sim/dwg_core_tb_top.sv
// Self-checking testbench of the waveform generator core.
// Assumes the host model drives the serial pins and the core clock runs at 20 MHz.
`timescale 1ns/10ps
module dwg_core_tb_top;
  logic               core_clk_i = 1'b0;
  logic               sys_rst_i  = 1'b1;
  logic               fs_w;
  logic               sc_w;
  logic               sd_w;
  dwg_pkg::dwg_wave_t wave;
  logic [9:0]         q_code[$];
  logic [2:0]         q_flag[$];
  event               ev_code;
  event               ev_flag;
  int                 failures  = 0;
  int                 tests_run = 0;

  // The clock toggles every half period of 25 ns.
  always #25 core_clk_i = ~core_clk_i;

  dwg_host_model host (
    .core_clk_i   (core_clk_i),
    .frame_sync_o (fs_w),
    .serial_clk_o (sc_w),
    .serial_data_o(sd_w)
  );

  dwg_core uut (
    .core_clk_i      (core_clk_i),
    .sys_rst_i       (sys_rst_i),
    .frame_sync_i    (fs_w),
    .serial_clk_i    (sc_w),
    .serial_data_in_i(sd_w),
    .wave_out_o      (wave)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Compares the converter code with the oldest noted expectation.
  task automatic cmp_code();
    logic [9:0] e;
    e = q_code.pop_front();
    tests_run++;
    if (wave.code !== e || $isunknown(wave.code)) begin
      failures++;
      $display("[FAIL] %0t code %h expected %h", $time, wave.code, e);
    end
  endtask

  // Compares bit value, bit select and converter power-down together.
  task automatic cmp_flag();
    logic [2:0] e;
    e = q_flag.pop_front();
    tests_run++;
    if ({wave.bit_val, wave.bit_sel, wave.conv_off} !== e
        || $isunknown({wave.bit_val, wave.bit_sel, wave.conv_off})) begin
      failures++;
      $display("[FAIL] %0t flags %b expected %b", $time,
               {wave.bit_val, wave.bit_sel, wave.conv_off}, e);
    end
  endtask

  // The watcher takes each note off its queue when a result is announced.
  always @(ev_code) cmp_code();
  always @(ev_flag) cmp_flag();

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask

  task automatic exp_code(input logic [9:0] v);
    q_code.push_back(v);
    ->ev_code;
    #1;
  endtask

  task automatic exp_flag(input logic [2:0] v);
    q_flag.push_back(v);
    ->ev_flag;
    #1;
  endtask

  function automatic logic [15:0] bt(input int b);
    return 16'h0001 << b;
  endfunction

  // Triangle code of a phase: rising in the first half, falling in the second.
  function automatic logic [9:0] tri_code(input logic [11:0] p);
    return p[11] ? ~p[10:1] : p[10:1];
  endfunction

  // Lets the ramp run, then checks the code advances by the step over one cycle.
  task automatic measure(input logic [9:0] step);
    logic [9:0] c;
    tick(30);
    c = wave.code;
    tick(1);
    exp_code(c + step);
  endtask

  // Cuts a hung run short well past the expected length of the tests.
  initial begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    wrap_up();
  end

  // Main sequence of scenarios.
  initial begin
    logic [11:0] pa;
    logic [11:0] pb;
    logic [9:0]  c;
    int          i;
    void'($urandom(57903));
    tick(2);
    sys_rst_i = 1'b0;
    tick(4);
    exp_code(dwg_pkg::MIDSCALE);
    exp_flag(3'h0);
    host.send_word(bt(dwg_pkg::BIT_RESET) | bt(dwg_pkg::BIT_MODE));
    exp_code(dwg_pkg::MIDSCALE);
    // Both offsets written with random values, then each one chosen in turn.
    for (i = 0; i < 4; i++) begin
      pa = 12'($urandom);
      pb = 12'($urandom);
      host.send_word({2'h3, 1'b0, 1'($urandom), pa});
      host.send_word({2'h3, 1'b1, 1'($urandom), pb});
      host.send_word(bt(dwg_pkg::BIT_MODE) | (i[0] ? bt(dwg_pkg::BIT_PSEL) : 16'h0000));
      tick(10);
      exp_code(tri_code(i[0] ? pb : pa));
    end
    // Bit output modes with the phase frozen at the first offset.
    host.send_word(bt(dwg_pkg::BIT_OPBIT) | bt(dwg_pkg::BIT_DIRECT));
    tick(10);
    exp_flag({~pa[11], 2'b10});
    host.send_word(bt(dwg_pkg::BIT_OPBIT) | bt(dwg_pkg::BIT_DIRECT) | bt(dwg_pkg::BIT_DACOFF));
    exp_flag({~pa[11], 2'b11});
    host.send_word(bt(dwg_pkg::BIT_OPBIT) | bt(dwg_pkg::BIT_MODE));
    exp_flag(3'b010);
    exp_code(dwg_pkg::MIDSCALE);
    // Second word by a half write, first word by a paired full write.
    host.send_word({2'h3, 14'h0000});
    host.send_word(bt(dwg_pkg::BIT_HALF) | bt(dwg_pkg::BIT_RESET));
    host.send_word({2'h2, 14'h0018});
    host.send_word(bt(dwg_pkg::BIT_FULL) | bt(dwg_pkg::BIT_RESET));
    host.send_word({2'h1, 14'h0000});
    host.send_word({2'h1, 14'h0010});
    host.send_word(bt(dwg_pkg::BIT_MODE));
    measure(10'h002);
    // Clock off freezes the ramp, yet a select change is still taken.
    host.send_word(bt(dwg_pkg::BIT_MODE) | bt(dwg_pkg::BIT_CLKOFF));
    tick(5);
    c = wave.code;
    tick(40);
    exp_code(c);
    exp_flag(3'b000);
    host.send_word(bt(dwg_pkg::BIT_MODE) | bt(dwg_pkg::BIT_CLKOFF) | bt(dwg_pkg::BIT_FSEL));
    exp_code(c);
    host.send_word(bt(dwg_pkg::BIT_MODE) | bt(dwg_pkg::BIT_FSEL));
    measure(10'h003);
    wrap_up();
  end
endmodule

// File: sim/dwg_host_model.sv
// Behavioural host that writes 16-bit words over the three-wire serial link.
// Assumes the core clock paces it; every change lands 2 ns after a rising edge.
`timescale 1ns/10ps
module dwg_host_model (
  input  wire logic core_clk_i,
  output logic      frame_sync_o,
  output logic      serial_clk_o,
  output logic      serial_data_o
);
  // Each serial clock level is held six core cycles, above the two the core needs.
  localparam int HALF_CYC = 6;

  // The link idles with sync high and the serial clock standing high.
  initial begin
    frame_sync_o  = 1'b1;
    serial_clk_o  = 1'b1;
    serial_data_o = 1'b0;
  end

  // Waits whole core cycles, then steps just past the edge.
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask

  // Sends one framed word, most significant bit first.
  task automatic send_word(input logic [15:0] w);
    int b;
    wait_cyc(1);
    frame_sync_o = 1'b0;
    for (b = 15; b >= 0; b--) begin
      serial_data_o = w[b];
      wait_cyc(HALF_CYC);
      serial_clk_o = 1'b0;
      wait_cyc(HALF_CYC);
      serial_clk_o = 1'b1;
    end
    wait_cyc(HALF_CYC);
    frame_sync_o  = 1'b1;
    serial_data_o = ~serial_data_o; // The released line no longer shows the last bit.
    wait_cyc(8);
  endtask
endmodule
